// ---- hw/led_stage_pkg.sv ----
// Shared constants and types for the LED output stage and reset-call logic.
package led_stage_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 200_000_000;
  localparam int PWM_STEPS       = 256;
  localparam int CH_PWM_HZ       = 97_000;
  localparam int GRP_DIM_HZ      = 190;
  localparam int BLINK_DIV       = 24;
  // Cycles per PWM step; all three figures round down.
  localparam int CH_TICK_CYCLES  = CLK_HZ / (CH_PWM_HZ * PWM_STEPS);
  localparam int GRP_DIM_CYCLES  = CLK_HZ / (GRP_DIM_HZ * PWM_STEPS);
  localparam int BLINK_CYCLES    = CLK_HZ / (BLINK_DIV * PWM_STEPS);

  // ----------------------------------------------------------------
  // Reset-call byte values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_CALL_ADDR = 8'h06;
  localparam logic [7:0] RESET_KEY_FIRST = 8'ha5;
  localparam logic [7:0] RESET_KEY_SECOND = 8'h5a;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CH_OFF     = 2'b00,
    CH_ON      = 2'b01,
    CH_PWM     = 2'b10,
    CH_PWM_GRP = 2'b11
  } channel_state_t;

  typedef enum logic [1:0] {
    DIS_LOW    = 2'b00,
    DIS_HIGH   = 2'b01,
    DIS_HIGHZ  = 2'b10,
    DIS_RSVD   = 2'b11
  } disabled_level_t;

  typedef enum logic [2:0] {
    PH_IDLE   = 3'b000,
    PH_ADDR   = 3'b001,
    PH_KEY1   = 3'b010,
    PH_KEY2   = 3'b011,
    PH_DONE   = 3'b100
  } link_phase_t;

endpackage : led_stage_pkg

// ---- hw/reset_call_link.sv ----
// Serial-clock domain receiver that checks the reset-call byte sequence.
`timescale 1ns/100ps
module reset_call_link (
  input  wire logic scl_clk,
  input  wire logic reset_n,
  input  wire logic sda_i,
  output logic      ack,
  output logic      key_ok
);
  import led_stage_pkg::*;

  typedef struct packed {
    logic [1:0]  rst_sync;
    link_phase_t phase;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic        ack;
    logic        key_ok;
  } link_state_t;

  link_state_t s;
  link_state_t next_s;
  logic        sda_high;
  logic [7:0]  byte_in;
  logic        start_seen;

  // ----------------------------------------------------------------
  // Sampling
  // ----------------------------------------------------------------
  // Data is stable while the clock is high, so the rising edge takes it.
  always_ff @(posedge scl_clk) begin
    sda_high <= sda_i;
  end

  // A high level at the rise and a low level at the fall is a start.
  assign start_seen = sda_high & ~sda_i;
  assign byte_in    = {s.shift[6:0], sda_high};

  // ----------------------------------------------------------------
  // Byte sequencer, stepping on the falling clock edge
  // ----------------------------------------------------------------
  // The acknowledge is changed on the fall so it is stable while high.
  always_comb begin
    next_s          = s;
    next_s.rst_sync = {s.rst_sync[0], reset_n};
    if (!s.rst_sync[1]) begin
      next_s.phase   = PH_IDLE;
      next_s.bit_cnt = 4'h0;
      next_s.ack     = 1'b0;
      next_s.key_ok  = 1'b0;
    end else if (start_seen) begin
      next_s.phase   = PH_ADDR;
      next_s.bit_cnt = 4'h0;
      next_s.ack     = 1'b0;
      next_s.key_ok  = 1'b0;
    end else if (s.bit_cnt == BITS_PER_BYTE) begin
      next_s.bit_cnt = 4'h0;
      next_s.ack     = 1'b0;
    end else begin
      next_s.shift   = byte_in;
      next_s.bit_cnt = s.bit_cnt + 4'h1;
      if (s.bit_cnt == BITS_PER_BYTE - 4'h1) begin
        next_s.ack   = 1'b0;
        next_s.phase = PH_IDLE;
        case (s.phase)
          PH_ADDR: begin
            if (byte_in == RESET_CALL_ADDR) begin
              next_s.ack   = 1'b1;
              next_s.phase = PH_KEY1;
            end
          end
          PH_KEY1: begin
            if (byte_in == RESET_KEY_FIRST) begin
              next_s.ack   = 1'b1;
              next_s.phase = PH_KEY2;
            end
          end
          PH_KEY2: begin
            if (byte_in == RESET_KEY_SECOND) begin
              next_s.ack    = 1'b1;
              next_s.key_ok = 1'b1;
              next_s.phase  = PH_DONE;
            end
          end
          PH_DONE: begin
            next_s.key_ok = 1'b0;
          end
          default: begin
            next_s.phase = PH_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(negedge scl_clk) begin
    s <= next_s;
  end

  assign ack    = s.ack;
  assign key_ok = s.key_ok;

endmodule : reset_call_link

// ---- hw/led_output_stage.sv ----
// Eight-channel LED output stage with PWM, group control and reset call.
// How it works
// - Reset puts all stage state in defaults; the serial receiver resets only on serial clock falls.
// - Reset-call address is acknowledged only as the full write byte.
// - Reset-call address with read direction gets no acknowledge.
// - First key byte is acknowledged only when it matches the first key.
// - Second key byte is acknowledged only when it matches the second key.
// - Any byte after the two keys is never acknowledged.
// - Correct keys then stop return the PWM counters, arming and acknowledge hold to power-up values.
// - Malformed sequences never cause a reset.
// - Inversion applies only with the gate low; else disabled level rules.
// - Open-drain never drives high; inactive high becomes high impedance.
// - Inverted totem-pole PWM drives both transistors with inverted PWM.
// - Combined non-inverted totem-pole swings by channel and group duty.
// - Each channel has its own fixed-rate 256-step duty PWM.
// - Only one group signal is applied: dimming or blinking.
// - Group dimming is a slower fixed-rate eight-bit duty PWM.
// - Group blinking has a 256-step period and eight-bit duty.
// - Two-bit state: off, on, individual, individual plus group.
// - With the gate high all outputs take the disabled level.
// - Blink select picks blinking with period, else dimming.
// - Blink period is period field plus one, over twenty-four seconds.
`timescale 1ns/100ps
module led_output_stage #(
  parameter int N_CH          = 8,
  parameter int GRP_DIM_TICKS = led_stage_pkg::GRP_DIM_CYCLES,
  parameter int BLINK_TICKS   = led_stage_pkg::BLINK_CYCLES
) (
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire logic                    scl_clk,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe,
  input  wire logic                    output_enable_n,
  input  wire logic [2*N_CH-1:0]       channel_state_register,
  input  wire logic [N_CH-1:0][7:0]    channel_duty,
  input  wire logic [7:0]              group_duty,
  input  wire logic [7:0]              group_period,
  input  wire logic                    group_blink_select,
  input  wire logic                    output_polarity_invert,
  input  wire logic                    totem_pole_select,
  input  wire led_stage_pkg::disabled_level_t disabled_output_level,
  output logic [N_CH-1:0]              led_o,
  output logic [N_CH-1:0]              led_oe,
  output logic                         soft_reset_call
);
  import led_stage_pkg::*;

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  localparam logic [3:0]  CH_TICK_LAST  = 4'(CH_TICK_CYCLES - 1);
  localparam logic [15:0] DIM_TICK_LAST = 16'(GRP_DIM_TICKS - 1);
  localparam logic [15:0] BLK_TICK_LAST = 16'(BLINK_TICKS - 1);

  // ----------------------------------------------------------------
  // Output mapping functions
  // ----------------------------------------------------------------
  // Returns {upper, lower} transistor enables for an enabled output.
  function automatic logic [1:0] enabled_drive(
    input logic active,
    input logic invert,
    input logic totem
  );
    logic pull_low;
    pull_low = active ^ invert;
    if (pull_low) begin
      enabled_drive = 2'b01;
    end else begin
      enabled_drive = {totem, 1'b0};
    end
  endfunction : enabled_drive

  // Returns {upper, lower} for the forced level while the gate is high.
  function automatic logic [1:0] disabled_drive(
    input disabled_level_t level,
    input logic            totem
  );
    case (level)
      DIS_LOW:  disabled_drive = 2'b01;
      DIS_HIGH: disabled_drive = {totem, 1'b0};
      default:  disabled_drive = 2'b00; // Reserved code floats the pin.
    endcase
  endfunction : disabled_drive

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]      oe_sync;
    logic [1:0]      scl_sync;
    logic [1:0]      sda_sync;
    logic            sda_last;
    logic [1:0]      key_sync;
    logic            key_last;
    logic            armed;
    logic            link_hold;
    logic            soft_pulse;
    logic [3:0]      ch_pre;
    logic [7:0]      ch_cnt;
    logic [15:0]     grp_pre;
    logic [7:0]      grp_rep;
    logic [7:0]      grp_cnt;
    logic [N_CH-1:0] led_o;
    logic [N_CH-1:0] led_oe;
  } stage_state_t;

  stage_state_t s;
  stage_state_t next_s;

  logic link_ack;
  logic link_key_ok;
  logic bus_start;
  logic bus_stop;
  logic key_rise;
  logic key_fall;
  logic grp_step;
  logic grp_active;

  // ----------------------------------------------------------------
  // Serial-clock side
  // ----------------------------------------------------------------
  // The byte checker runs on the master's clock; only its key level and
  // acknowledge come back, the level through a two-stage synchroniser.
  reset_call_link u_link (
    .scl_clk (scl_clk),
    .reset_n (reset_n),
    .sda_i   (sda_i),
    .ack     (link_ack),
    .key_ok  (link_key_ok)
  );

  // The pin is open drain: only ever pulled low. The hold term keeps the
  // line released after any reset until a fresh start is seen, because
  // the serial clock may be stopped and its state is then stale.
  assign sda_o  = 1'b0;
  assign sda_oe = link_ack & ~s.link_hold;

  // ----------------------------------------------------------------
  // Bus condition and key detection on the system clock
  // ----------------------------------------------------------------
  // Start and stop are seen as data edges while the clock stays high.
  assign bus_start = s.scl_sync[1] & s.sda_last & ~s.sda_sync[1];
  assign bus_stop  = s.scl_sync[1] & ~s.sda_last & s.sda_sync[1];
  assign key_rise  = s.key_sync[1] & ~s.key_last;
  assign key_fall  = ~s.key_sync[1] & s.key_last;

  // ----------------------------------------------------------------
  // Group timing
  // ----------------------------------------------------------------
  // The blink period stretches each step by period plus one base ticks.
  always_comb begin
    grp_step = 1'b0;
    if (group_blink_select) begin
      grp_step = (s.grp_pre >= BLK_TICK_LAST)
               && (s.grp_rep >= group_period);
    end else begin
      grp_step = (s.grp_pre >= DIM_TICK_LAST);
    end
  end

  assign grp_active = s.grp_cnt < group_duty;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0]     drive;
    logic           active;
    channel_state_t ch_state;
    drive        = 2'b00;
    active       = 1'b0;
    ch_state     = CH_OFF;
    next_s       = s;

    // Pins cross in two stages; only stage two is read elsewhere.
    next_s.oe_sync  = {s.oe_sync[0], output_enable_n};
    next_s.scl_sync = {s.scl_sync[0], scl_clk};
    next_s.sda_sync = {s.sda_sync[0], sda_i};
    next_s.sda_last = s.sda_sync[1];
    next_s.key_sync = {s.key_sync[0], link_key_ok};
    next_s.key_last = s.key_sync[1];
    next_s.soft_pulse = 1'b0;

    // A new frame frees the acknowledge path again.
    if (bus_start) begin
      next_s.link_hold = 1'b0;
    end

    // Arming follows the key level; a rise wins over any clearing term.
    if (key_rise) begin
      next_s.armed = 1'b1;
    end else if (key_fall || bus_start || bus_stop) begin
      next_s.armed = 1'b0;
    end

    // Channel counter: one step per prescaled tick.
    if (s.ch_pre >= CH_TICK_LAST) begin
      next_s.ch_pre = 4'h0;
      next_s.ch_cnt = s.ch_cnt + 8'h01;
    end else begin
      next_s.ch_pre = s.ch_pre + 4'h1;
    end

    // Group counter: one prescaler shared by dimming and blinking.
    if (grp_step) begin
      next_s.grp_pre = 16'h0000;
      next_s.grp_rep = 8'h00;
      next_s.grp_cnt = s.grp_cnt + 8'h01;
    end else if (group_blink_select && s.grp_pre >= BLK_TICK_LAST) begin
      next_s.grp_pre = 16'h0000;
      next_s.grp_rep = s.grp_rep + 8'h01;
    end else begin
      next_s.grp_pre = s.grp_pre + 16'h0001;
    end

    // Per-channel output mapping, registered so pins never glitch.
    for (int i = 0; i < N_CH; i++) begin
      ch_state = channel_state_t'(channel_state_register[2*i +: 2]);
      case (ch_state)
        CH_OFF:     active = 1'b0;
        CH_ON:      active = 1'b1;
        CH_PWM:     active = s.ch_cnt < channel_duty[i];
        CH_PWM_GRP: active = (s.ch_cnt < channel_duty[i])
                           & grp_active;
        default:    active = 1'b0;
      endcase
      if (s.oe_sync[1]) begin
        drive = disabled_drive(disabled_output_level,
                               totem_pole_select);
      end else begin
        drive = enabled_drive(active, output_polarity_invert,
                              totem_pole_select);
      end
      next_s.led_o[i]  = drive[1];
      next_s.led_oe[i] = drive[1] | drive[0];
    end

    // A stop after a fully accepted key pair restarts the counters; the
    // pins are not cleared and keep being driven from the level inputs.
    if (bus_stop && s.armed) begin
      next_s.soft_pulse = 1'b1;
      next_s.armed      = 1'b0;
      next_s.link_hold  = 1'b1;
      next_s.ch_pre     = 4'h0;
      next_s.ch_cnt     = 8'h00;
      next_s.grp_pre    = 16'h0000;
      next_s.grp_rep    = 8'h00;
      next_s.grp_cnt    = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset leaves the synchroniser stages at the idle bus level, so no
  // false start or stop is seen as the pins settle after release.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s            <= '0;
      s.oe_sync    <= 2'b11;
      s.scl_sync   <= 2'b11;
      s.sda_sync   <= 2'b11;
      s.sda_last   <= 1'b1;
      s.link_hold  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign led_o           = s.led_o;
  assign led_oe          = s.led_oe;
  assign soft_reset_call = s.soft_pulse;

endmodule : led_output_stage

// ---- bench/led_output_stage_properties.sv ----
// Concurrent checks on the ports of the LED output stage.
`timescale 1ns/100ps
module led_output_stage_properties #(
  parameter int N_CH          = 8,
  parameter int GRP_DIM_TICKS = led_stage_pkg::GRP_DIM_CYCLES,
  parameter int BLINK_TICKS   = led_stage_pkg::BLINK_CYCLES
) (
  input wire logic                          sys_clk,
  input wire logic                          reset_n,
  input wire logic                          output_enable_n,
  input wire logic [2*N_CH-1:0]             channel_state_register,
  input wire logic [N_CH-1:0][7:0]          channel_duty,
  input wire logic                          output_polarity_invert,
  input wire logic                          totem_pole_select,
  input wire led_stage_pkg::disabled_level_t disabled_output_level,
  input wire logic [N_CH-1:0]               led_o,
  input wire logic [N_CH-1:0]               led_oe,
  input wire logic                          soft_reset_call
);
  import led_stage_pkg::*;
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic [2:0]      gcnt;
  logic            gate;
  logic            pi;
  logic            tp;
  disabled_level_t lv;
  logic [1:0]      st0;
  logic [7:0]      d0;
  logic            en_ok;
  logic            dis_ok;

  // Config seen one edge ago, and edges since the gate pin last moved;
  // the gate crosses two sync stages, so checks wait four edges.
  always_ff @(posedge sys_clk) begin
    pi  <= output_polarity_invert;
    tp  <= totem_pole_select;
    lv  <= disabled_output_level;
    st0 <= channel_state_register[1:0];
    d0  <= channel_duty[0];
    if (!reset_n) begin
      gcnt <= 3'h0;
      gate <= 1'b1;
    end else begin
      gate <= output_enable_n;
      gcnt <= (gate != output_enable_n) ? 3'h0 :
              ((gcnt == 3'h7) ? gcnt : gcnt + 3'h1);
    end
  end

  // Settled windows with the gate high or low.
  assign en_ok  = (gcnt >= 3'h4) && !gate;
  assign dis_ok = (gcnt >= 3'h4) && gate;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_pulse_single: assert property (
    soft_reset_call |=> !soft_reset_call)
    else $error("reset call pulse longer than one cycle");
  chk_upper_off_od: assert property (
    !$past(totem_pole_select) |-> led_o == '0)
    else $error("upper transistor on in open drain");
  chk_drive_needs_oe: assert property (
    (led_o & ~led_oe) == '0)
    else $error("high drive without enable");
  chk_dis_low: assert property (
    dis_ok && lv == DIS_LOW |-> led_oe == '1 && led_o == '0)
    else $error("disabled low level wrong");
  chk_dis_highz: assert property (
    dis_ok && lv inside {DIS_HIGHZ, DIS_RSVD} |-> led_oe == '0)
    else $error("disabled high impedance wrong");
  chk_dis_high: assert property (
    dis_ok && lv == DIS_HIGH |-> led_o == {N_CH{tp}} && led_oe == {N_CH{tp}})
    else $error("disabled high level wrong");
  chk_ch_off: assert property (
    en_ok && st0 == CH_OFF |-> led_oe[0] == (pi | tp) && led_o[0] == (!pi & tp))
    else $error("off channel mapping wrong");
  chk_ch_on: assert property (
    en_ok && st0 == CH_ON |-> led_oe[0] == (!pi | tp) && led_o[0] == (pi & tp))
    else $error("on channel mapping wrong");
  chk_zero_duty: assert property (
    en_ok && st0 == CH_PWM && d0 == 8'h00 |->
      led_oe[0] == (pi | tp) && led_o[0] == (!pi & tp))
    else $error("zero duty channel became active");
endmodule : led_output_stage_properties

bind led_output_stage led_output_stage_properties #(
  .N_CH(N_CH), .GRP_DIM_TICKS(GRP_DIM_TICKS), .BLINK_TICKS(BLINK_TICKS)
) u_props (
  .sys_clk(sys_clk), .reset_n(reset_n), .output_enable_n(output_enable_n),
  .channel_state_register(channel_state_register),
  .channel_duty(channel_duty),
  .output_polarity_invert(output_polarity_invert),
  .totem_pole_select(totem_pole_select),
  .disabled_output_level(disabled_output_level),
  .led_o(led_o), .led_oe(led_oe), .soft_reset_call(soft_reset_call)
);

// ---- bench/reset_call_master.sv ----
// Serial bus master model that sends reset-call frames.
`timescale 1ns/100ps
module reset_call_master (
  output logic      scl,
  output logic      sda_out,
  input  wire logic sda_in
);
  // ----------------------------------------------------------------
  // Frame generator
  // ----------------------------------------------------------------
  // The clock stands high between frames, as a real master leaves it.
  initial begin
    scl     = 1'b1;
    sda_out = 1'b1;
  end

  // START, bytes MSB first, STOP; the first missing acknowledge ends
  // the frame at once, because the reset counts as aborted.
  task automatic frame(input logic [7:0] b [4], input int n,
                       output int acked);
    logic ackbit;
    acked = 0;
    // The receiver marks a start by a clock rise with the data high, so
    // the frame opens with one clock pulse before the data falls.
    #1.3 scl = 1'b0;
    #3 sda_out = 1'b1;
    #3 scl = 1'b1;
    #6 sda_out = 1'b0;
    #12 scl = 1'b0;
    for (int i = 0; i < n; i++) begin
      for (int k = 7; k >= 0; k--) begin
        #1 sda_out = b[i][k];
        #5 scl = 1'b1;
        #6 scl = 1'b0;
      end
      #1 sda_out = 1'b1;
      #5 scl = 1'b1;
      #3 ackbit = sda_in;
      #3 scl = 1'b0;
      if (ackbit !== 1'b0) break;
      acked++;
    end
    #1 sda_out = 1'b0;
    #5 scl = 1'b1;
    #12 sda_out = 1'b1;
    #40;
  endtask : frame
endmodule : reset_call_master

// ---- bench/led_output_stage_tb_top.sv ----
// Self-checking bench for the LED output stage and reset call.
`timescale 1ns/100ps
module led_output_stage_tb_top;
  import led_stage_pkg::*;
  localparam int N = 8;
  logic            sys_clk  = 1'b0;
  logic            reset_n  = 1'b0;
  logic            gate_n   = 1'b1;
  logic [15:0]     states   = 16'h0000;
  logic [7:0][7:0] duty     = '0;
  logic [7:0]      gduty    = 8'h00;
  logic [7:0]      gper     = 8'h00;
  logic            blink    = 1'b0;
  logic            inv      = 1'b0;
  logic            totem    = 1'b0;
  disabled_level_t lvl      = DIS_LOW;
  logic            scl;
  logic            m_sda;
  logic            sda;
  logic            sda_o;
  logic            sda_oe;
  logic [N-1:0]    led_o;
  logic [N-1:0]    led_oe;
  logic            srst;
  logic [31:0]     rnd      = 32'h0001_8481;
  int              failures = 0;
  int              checks   = 0;
  int              pulses   = 0;
  int              act [N];

  // Open-drain bus with a pull-up: low when either party pulls.
  assign sda = m_sda & ~(sda_oe & ~sda_o);

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Counts reset-call pulses for the frame scenarios.
  always @(posedge sys_clk) begin
    if (srst === 1'b1) pulses <= pulses + 1;
  end

  led_output_stage #(.N_CH(N), .GRP_DIM_TICKS(4), .BLINK_TICKS(8)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl_clk(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .output_enable_n(gate_n),
    .channel_state_register(states), .channel_duty(duty),
    .group_duty(gduty), .group_period(gper), .group_blink_select(blink),
    .output_polarity_invert(inv), .totem_pole_select(totem),
    .disabled_output_level(lvl), .led_o(led_o), .led_oe(led_oe),
    .soft_reset_call(srst)
  );

  reset_call_master master (.scl(scl), .sda_out(m_sda), .sda_in(sda));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Expected {enable, drive} of one pin with its duty at zero.
  function automatic logic [1:0] exp_pin(input logic g,
      input disabled_level_t l, input logic [1:0] s, input logic iv,
      input logic tp);
    logic pl;
    pl = (s == CH_ON) ^ iv;
    if (g) return (l == DIS_LOW) ? 2'b10 : ((l == DIS_HIGH) ? {tp, tp} : 2'b00);
    return {pl | tp, ~pl & tp};
  endfunction : exp_pin

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Counts active cycles per channel; inversion is undone first.
  task automatic measure(input int cyc, input logic iv);
    for (int i = 0; i < N; i++) act[i] = 0;
    repeat (cyc) begin
      @(negedge sys_clk);
      for (int i = 0; i < N; i++) act[i] += int'((led_oe[i] & ~led_o[i]) ^ iv);
    end
  endtask : measure

  task automatic do_frame(input logic [7:0] b0, b1, b2, b3,
                          input int n, ea, ep);
    int got;
    int p0;
    p0 = pulses;
    master.frame('{b0, b1, b2, b3}, n, got);
    repeat (30) @(posedge sys_clk);
    check("acknowledged bytes", ea, got);
    check("reset pulses", ep, pulses - p0);
  endtask : do_frame

  task automatic complete_run();
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int hi;
    int win;
    repeat (6) @(posedge sys_clk);
    check("reset outputs", 0, {led_o, led_oe, sda_oe, srst});
    reset_n <= 1'b1;
    // Random static states; zero duty keeps PWM modes inactive.
    for (int t = 0; t < 40; t++) begin
      @(posedge sys_clk);
      rnd = lfsr(rnd);
      gate_n <= rnd[0];
      lvl    <= disabled_level_t'(rnd[2:1]);
      inv    <= rnd[3];
      totem  <= rnd[4];
      states <= rnd[20:5];
      gduty  <= rnd[28:21];
      repeat (7) @(posedge sys_clk);
      for (int i = 0; i < N; i++)
        check("pin state", exp_pin(gate_n, lvl, states[2*i+:2], inv, totem),
              {led_oe[i], led_o[i]});
    end
    // Individual duty, both polarities, full and zero corners.
    for (int v = 0; v < 2; v++) begin
      @(posedge sys_clk);
      rnd = lfsr(rnd);
      gate_n <= 1'b0;
      totem  <= 1'b1;
      inv    <= v[0];
      states <= 16'haaaa;
      duty   <= {lfsr(rnd), rnd[31:16], 16'h00ff};
      repeat (8) @(posedge sys_clk);
      measure(2048, v[0]);
      for (int i = 0; i < N; i++)
        check("duty count", duty[i] * CH_TICK_CYCLES, act[i]);
    end
    // Group dimming and blinking on top of a full channel duty.
    for (int c = 0; c < 4; c++) begin
      @(posedge sys_clk);
      states <= 16'hffff;
      inv    <= 1'b0;
      duty   <= '1;
      blink  <= c[1];
      gper   <= c[1] ? {7'h00, c[0]} : rnd[7:0];
      gduty  <= (c == 0) ? 8'h00 : 8'h80;
      win = (c == 3) ? 4096 : 2048;
      hi  = (c == 0) ? 0 : win / 2;
      repeat (40) @(posedge sys_clk);
      measure(win, 1'b0);
      for (int i = 0; i < N; i++)
        check("group count", 1, act[i] <= hi && act[i] >= hi - win / 256);
    end
    rnd = lfsr(rnd);
    do_frame(8'h07, 0, 0, 0, 1, 0, 0);
    do_frame(8'h06, 8'ha5, 8'h5a, 0, 3, 3, 1);
    do_frame(8'h06, rnd[7:0] & 8'hfe, 0, 0, 2, 1, 0);
    do_frame(8'h06, 8'ha5, rnd[15:8] | 8'h01, 0, 3, 2, 0);
    do_frame(8'h06, 8'ha5, 8'h5a, rnd[23:16], 4, 3, 0);
    do_frame(rnd[31:24] | 8'h08, 0, 0, 0, 1, 0, 0);
    // A second reset in mid-run, then the link must work again.
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("mid reset outputs", 0, {led_o, led_oe, sda_oe, srst});
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    do_frame(8'h06, 8'ha5, 8'h5a, 0, 3, 3, 1);
    complete_run();
  end

  // Cuts a hang short; the whole run needs well under half of this.
  initial begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    complete_run();
  end
endmodule : led_output_stage_tb_top
